// ===== design/agc_stage.sv
`timescale 1ns/1ns
module agc_stage (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [17:0] i_data,
	input wire logic i_cdma_mode,
	input wire logic [23:0] i_gain_a,
	input wire logic [23:0] i_gain_b,
	input wire logic [3:0] i_exp_below,
	input wire logic [3:0] i_exp_above,
	input wire logic [3:0] i_exp_zero,
	input wire logic [3:0] i_exp_sat,
	input wire logic [3:0] i_zero_mask,
	input wire logic [3:0] i_rounding_width_select,
	input wire logic [7:0] i_threshold,
	input wire logic i_round_disable,
	input wire logic i_freeze,
	input wire logic i_freeze_sync,
	input wire logic i_clear,
	input wire logic [3:0] i_zero_limit,
	input wire logic [3:0] i_sat_limit,
	input wire logic [15:0] i_adj_max,
	input wire logic [15:0] i_adj_min,
	input wire logic i_gain_mon,
	output logic o_valid,
	input wire logic i_ready,
	output logic [24:0] o_data,
	output logic [23:0] o_gain_a,
	output logic [23:0] o_gain_b
);
	localparam int AW = agc_pkg::ADJ_W;
	localparam int PW = agc_pkg::SAMPLE_W + agc_pkg::GAIN_W;

	logic sync_meta_q;
	logic sync_q;
	agc_pkg::path_type path_q;
	logic signed [AW-1:0] adj_q [2];
	logic [3:0] zcnt_q [2];
	logic [3:0] scnt_q [2];
	logic [24:0] word_d;
	logic [24:0] buf_data;
	logic buf_ready;
	logic buf_valid;
	logic take;
	logic freeze;
	logic side;
	logic signed [AW-1:0] adj_cur;
	logic signed [AW-1:0] gain_eff;
	logic signed [AW-1:0] gain_sat;
	logic signed [PW+1:0] prod;
	logic signed [PW+1:0] sample_sh;
	logic signed [24:0] full_q25;
	logic [7:0] mag;
	logic is_zero;
	logic is_sat;
	logic above;
	logic [3:0] code;
	logic [4:0] dexp;
	logic signed [AW-1:0] step;
	logic signed [AW-1:0] adj_next;
	logic signed [AW-1:0] lim_max;
	logic signed [AW-1:0] lim_min;
	logic [4:0] out_w;
	logic signed [24:0] rounded;
	logic [24:0] keep_mask;

	// Sync pin into the clock domain
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			sync_meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			sync_meta_q <= i_freeze_sync;
			sync_q <= sync_meta_q;
		end
	end

	assign freeze = i_freeze | sync_q;
	assign take = i_valid && buf_ready;
	assign o_ready = buf_ready;
	assign side = i_cdma_mode && (path_q == agc_pkg::PATH_DIV_I || path_q == agc_pkg::PATH_DIV_Q);
	assign adj_cur = adj_q[side];
	assign gain_eff = $signed({2'b00, (side ? i_gain_b : i_gain_a)}) + adj_cur;
	assign gain_sat = gain_eff[AW-1] ? '0
		: ((|gain_eff[AW-2:24]) ? 26'sh0FFFFFF : gain_eff);
	assign o_gain_a = gain_sat_of(0);
	assign o_gain_b = gain_sat_of(1);

	function automatic logic [23:0] gain_sat_of(input int s);
		logic signed [AW-1:0] g;
		g = $signed({2'b00, (s == 1 ? i_gain_b : i_gain_a)}) + adj_q[s];
		if (g[AW-1]) begin
			return 24'h000000;
		end else if (|g[AW-2:24]) begin
			return 24'hFFFFFF;
		end
		return g[23:0];
	endfunction

	// Product aligned with 12 fraction bits dropped
	assign prod = $signed(i_data) * $signed({1'b0, gain_sat[AW-2:0]});
	assign sample_sh = prod >>> agc_pkg::GAIN_FRAC_W;
	always_comb begin
		if (sample_sh > $signed(44'sh0000001FFFF)) begin
			full_q25 = 25'sh001FFFF;
		end else if (sample_sh < -$signed(44'sh00000020000)) begin
			full_q25 = 25'sh1FE0000;
		end else begin
			full_q25 = sample_sh[24:0];
		end
	end

	// Top 8 bits of saturated 18-bit result, inverted when negative
	always_comb begin
		mag = full_q25[17] ? 8'(~full_q25[17:10]) : full_q25[17:10];
	end
	assign is_zero = ((full_q25[17:10] & {4'hF, ~i_zero_mask}) == 8'h00)
		|| ((~full_q25[17:10] & {4'hF, ~i_zero_mask}) == 8'h00 && full_q25[17]);
	assign is_sat = (mag == agc_pkg::MAG_MAX);
	assign above = (mag > i_threshold);

	always_comb begin
		if (scnt_q[side] > i_sat_limit) begin
			code = i_exp_sat;
		end else if (zcnt_q[side] > i_zero_limit) begin
			code = i_exp_zero;
		end else if (above) begin
			code = i_exp_above;
		end else begin
			code = i_exp_below;
		end
	end
	assign dexp = {1'b0, code} + 5'(agc_pkg::EXP_BIAS);
	assign step = gain_sat >>> dexp;

	assign lim_max = $signed({2'b00, i_adj_max, 8'h00});
	assign lim_min = $signed({{2{i_adj_min[15]}}, i_adj_min, 8'h00});
	always_comb begin
		adj_next = adj_cur;
		if (above) begin
			if (!(adj_cur < lim_min)) begin
				adj_next = adj_cur - step;
			end
		end else if (!(adj_cur > lim_max)) begin
			adj_next = adj_cur + step;
		end
	end

	// Adjustment accumulators, one for signal I/Q and one for diversity I/Q
	always_ff @(posedge i_mclk) begin
		if (i_srst || i_clear) begin
			adj_q[0] <= agc_pkg::ADJ_RESET;
			adj_q[1] <= agc_pkg::ADJ_RESET;
		end else if (take && !freeze) begin
			adj_q[side] <= adj_next;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			zcnt_q[0] <= agc_pkg::CNT_RESET;
			zcnt_q[1] <= agc_pkg::CNT_RESET;
			scnt_q[0] <= agc_pkg::CNT_RESET;
			scnt_q[1] <= agc_pkg::CNT_RESET;
		end else if (take) begin
			if (is_zero) begin
				zcnt_q[side] <= (zcnt_q[side] == 4'hF) ? 4'hF : zcnt_q[side] + 4'h1;
			end else begin
				zcnt_q[side] <= (zcnt_q[side] == 4'h0) ? 4'h0 : zcnt_q[side] - 4'h1;
			end
			if (is_sat) begin
				scnt_q[side] <= (scnt_q[side] == 4'hF) ? 4'hF : scnt_q[side] + 4'h1;
			end else begin
				scnt_q[side] <= (scnt_q[side] == 4'h0) ? 4'h0 : scnt_q[side] - 4'h1;
			end
		end
	end

	// I, Q, then diversity I, Q in CDMA
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			path_q <= agc_pkg::PATH_SIG_I;
		end else if (take) begin
			case (path_q)
				agc_pkg::PATH_SIG_I: path_q <= agc_pkg::PATH_SIG_Q;
				agc_pkg::PATH_SIG_Q: path_q <= i_cdma_mode ? agc_pkg::PATH_DIV_I : agc_pkg::PATH_SIG_I;
				agc_pkg::PATH_DIV_I: path_q <= agc_pkg::PATH_DIV_Q;
				agc_pkg::PATH_DIV_Q: path_q <= agc_pkg::PATH_SIG_I;
				default: path_q <= agc_pkg::PATH_SIG_I;
			endcase
		end
	end

	// Round to 18 - i_rounding_width_select bits, kept MSB-aligned in bits 17:0
	assign out_w = 5'(agc_pkg::SAMPLE_W) - {1'b0, i_rounding_width_select};
	always_comb begin
		keep_mask = ~(25'h1FFFFFF >> (25 - (agc_pkg::SAMPLE_W - out_w)));
		if (out_w == 5'(agc_pkg::SAMPLE_W)) begin
			rounded = full_q25;
		end else if (full_q25 + $signed(25'h0000001 << (5'(agc_pkg::SAMPLE_W) - out_w - 5'h1))
				> 25'sh001FFFF) begin
			rounded = 25'sh001FFFF & $signed(keep_mask);
		end else begin
			rounded = (full_q25 + $signed(25'h0000001 << (5'(agc_pkg::SAMPLE_W) - out_w - 5'h1)))
				& $signed(keep_mask);
		end
	end

	always_comb begin
		if (freeze && !i_gain_mon) begin
			word_d = sample_sh[24:0];
		end else if (i_gain_mon) begin
			if (path_q == agc_pkg::PATH_SIG_I || path_q == agc_pkg::PATH_DIV_I) begin
				word_d = {7'h00, rounded[17:10], gain_sat[23:16], 2'b00};
			end else begin
				word_d = {7'h00, rounded[17:10], gain_sat[15:10], is_zero, is_sat, 2'b00};
			end
		end else if (i_round_disable) begin
			word_d = {{7{full_q25[17]}}, full_q25[17:0]};
		end else begin
			word_d = {{7{rounded[17]}}, rounded[17:0]};
		end
	end

	agc_out_buffer #(
		.WIDTH(25)
	) u_buf (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_valid(i_valid),
		.o_ready(buf_ready),
		.i_data(word_d),
		.o_valid(buf_valid),
		.i_ready(i_ready),
		.o_data(buf_data)
	);
	assign o_valid = buf_valid;
	assign o_data = buf_data;

	freeze_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(freeze && !i_clear) |=> (adj_q[0] == $past(adj_q[0]) && adj_q[1] == $past(adj_q[1])))
		else $error("adjustment moved under freeze");
	clear_zero_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		i_clear |=> (adj_q[0] == '0 && adj_q[1] == '0))
		else $error("clear did not zero adjustment");
	idle_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		!take |=> (path_q == $past(path_q)))
		else $error("path advanced without sample");
	umts_path_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!i_cdma_mode && take && path_q == agc_pkg::PATH_SIG_Q)
		|=> (path_q == agc_pkg::PATH_SIG_I))
		else $error("diversity path used in umts");
	raise_dir_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(take && !freeze && !i_clear && !above && !side && adj_cur <= lim_max)
		|=> adj_q[0] >= $past(adj_cur))
		else $error("gain fell below threshold");
	lower_dir_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(take && !freeze && !i_clear && above && !side && adj_cur >= lim_min)
		|=> adj_q[0] <= $past(adj_cur))
		else $error("gain rose above threshold");
	exp_map_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		dexp >= 5'd3 && dexp <= 5'd18)
		else $error("step exponent out of range");
	sat_select_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(scnt_q[side] > i_sat_limit) |-> code == i_exp_sat)
		else $error("saturation exponent not chosen");
	zero_select_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(scnt_q[side] <= i_sat_limit && zcnt_q[side] > i_zero_limit) |-> code == i_exp_zero)
		else $error("zero exponent not chosen");
	status_bits_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(i_gain_mon && (path_q == agc_pkg::PATH_SIG_Q || path_q == agc_pkg::PATH_DIV_Q))
		|-> (word_d[2] == (mag == agc_pkg::MAG_MAX) && word_d[1:0] == 2'b00))
		else $error("monitor status bits wrong");
	sequence sync_held_s;
		i_freeze_sync [*3];
	endsequence
	sync_freeze_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		sync_held_s |-> freeze)
		else $error("sync did not freeze");
endmodule

// ===== design/agc_pkg.sv
package agc_pkg;
	localparam int SAMPLE_W = 18;
	localparam int GAIN_W = 24;
	localparam int GAIN_FRAC_W = 12;
	localparam int ADJ_W = 26;
	localparam int FULL_W = 25;
	localparam int LIMIT_W = 16;
	localparam int LIMIT_FRAC_W = 4;
	localparam int EXP_W = 4;
	localparam int CNT_W = 4;
	localparam int MAG_W = 8;
	localparam int EXP_BIAS = 3;
	localparam int MIN_ROUND_W = 3;
	localparam int BUF_DEPTH = 2;
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
	localparam logic [MAG_W-1:0] MAG_MAX = 8'h7F;
	localparam logic [ADJ_W-1:0] ADJ_RESET = 26'h0000000;
	typedef enum logic [1:0] {
		PATH_SIG_I = 2'b00,
		PATH_SIG_Q = 2'b01,
		PATH_DIV_I = 2'b11,
		PATH_DIV_Q = 2'b10
	} path_type;
endpackage

// ===== design/agc_out_buffer.sv
`timescale 1ns/1ns
module agc_out_buffer #(
	parameter int WIDTH = 25
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	logic [WIDTH-1:0] mem_q [agc_pkg::BUF_DEPTH];
	logic rd_ptr_q;
	logic wr_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign o_ready = (count_q != 2'h2);
	assign o_valid = (count_q != 2'h0);
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_data = mem_q[rd_ptr_q];

	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_data;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	full_block_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(count_q == 2'h2 && !pop) |=> (count_q == 2'h2 && !o_ready))
		else $error("buffer lost full state");
endmodule

// ===== test/agc_sink_model.sv
`timescale 1ns/1ns
module agc_sink_model (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire logic [24:0] i_data,
	output logic o_ready,
	output logic [24:0] o_last,
	output logic [7:0] o_count
);
	always_ff @(posedge i_mclk) begin
		o_ready <= ~i_srst & ~i_stall;
		if (i_srst) begin
			o_count <= 8'h00;
		end else if (i_valid && o_ready) begin
			o_last <= i_data;
			o_count <= o_count + 8'h01;
		end
	end
endmodule

// ===== test/ddc_automatic_gain_control_test.sv
`timescale 1ns/1ns
module ddc_automatic_gain_control_test;
	logic mclk = 1'b0, srst = 1'b1, valid = 1'b0, cdma = 1'b0, rnd_dis = 1'b0;
	logic frz = 1'b0, fsync = 1'b0, clr = 1'b0, gmon = 1'b0, stall = 1'b0;
	logic [17:0] data = 18'h00000;
	logic [23:0] gain = 24'h001000;
	logic [3:0] e_blw = 4'h2, e_abv = 4'h2, e_zro = 4'h2, e_sat = 4'h2;
	logic [3:0] zmask = 4'h0, rws = 4'h0, zlim = 4'hF, slim = 4'hF;
	logic [7:0] thr = 8'h7E;
	logic [15:0] amax = 16'h7FFF, amin = 16'h8000;
	logic in_ready, ovalid, out_ready;
	logic [24:0] odata, last;
	logic [23:0] ga, gb;
	logic [7:0] cnt, c0;
	int failures = 0, cmp_count = 0, cycles = 0, w;
	agc_stage agc_stage_inst (.i_mclk(mclk), .i_srst(srst), .i_valid(valid),
		.o_ready(in_ready), .i_data(data), .i_cdma_mode(cdma), .i_gain_a(gain),
		.i_gain_b(gain), .i_exp_below(e_blw), .i_exp_above(e_abv), .i_exp_zero(e_zro),
		.i_exp_sat(e_sat), .i_zero_mask(zmask), .i_rounding_width_select(rws),
		.i_threshold(thr), .i_round_disable(rnd_dis), .i_freeze(frz), .i_freeze_sync(fsync),
		.i_clear(clr), .i_zero_limit(zlim), .i_sat_limit(slim), .i_adj_max(amax),
		.i_adj_min(amin), .i_gain_mon(gmon), .o_valid(ovalid), .i_ready(out_ready),
		.o_data(odata), .o_gain_a(ga), .o_gain_b(gb));
	agc_sink_model agc_sink_model_inst (.i_mclk(mclk), .i_srst(srst), .i_stall(stall),
		.i_valid(ovalid), .i_data(odata), .o_ready(out_ready), .o_last(last), .o_count(cnt));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("compares=%0d failures=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic check(input logic [24:0] seen, input logic [24:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic send(input logic [17:0] d, output int n);
		logic r;
		valid <= 1'b1;
		data <= d;
		r = 1'b0;
		for (n = 0; n < 50 && !r; n++) begin
			#1 r = in_ready;
			@(posedge mclk);
		end
		check(r, 1'b1);
	endtask
	task automatic word(input logic [17:0] d, input logic [24:0] exp);
		send(d, w);
		valid <= 1'b0;
		tick(3);
		check(last, exp);
	endtask
	task automatic gsee(input logic b, input logic [23:0] exp);
		#1 check(b ? gb : ga, exp);
		@(posedge mclk);
	endtask
	task automatic prep(input logic f, input logic [23:0] g);
		frz <= f;
		gain <= g;
		tick(1);
		clr <= 1'b1;
		tick(2);
		clr <= 1'b0;
		tick(2);
	endtask
	task automatic do_reset();
		srst <= 1'b1;
		tick(4);
		srst <= 1'b0;
		tick(1);
	endtask
	initial begin
		tick(4);
		srst <= 1'b0;
		tick(1);
		#1 check(ovalid, 1'b0);
		gsee(1'b0, 24'h001000);
		prep(1'b1, 24'h002000);
		word(18'h00100, 25'h0000200);
		word(18'h3FF00, 25'h1FFFE00);
		prep(1'b1, 24'h000800);
		word(18'h00100, 25'h0000080);
		prep(1'b1, 24'h004000);
		word(18'h1FFFF, 25'h007FFFC);
		prep(1'b0, 24'h004000);
		word(18'h1FFFF, 25'h001FFFF);
		rws <= 4'hE;
		prep(1'b0, 24'h001000);
		word(18'h0F000, 25'h0010000);
		rnd_dis <= 1'b1;
		prep(1'b0, 24'h001000);
		word(18'h0F000, 25'h000F000);
		rnd_dis <= 1'b0;
		rws <= 4'h0;
		prep(1'b0, 24'h001000);
		word(18'h00400, 25'h0000400);
		gsee(1'b0, 24'h001080);
		fsync <= 1'b1;
		tick(3);
		word(18'h00400, 25'h0000420);
		gsee(1'b0, 24'h001080);
		fsync <= 1'b0;
		amax <= 16'h0000;
		prep(1'b0, 24'h001000);
		word(18'h00400, 25'h0000400);
		word(18'h00400, 25'h0000420);
		gsee(1'b0, 24'h001080);
		amax <= 16'h7FFF;
		amin <= 16'h0000;
		thr <= 8'h00;
		e_abv <= 4'h0;
		prep(1'b0, 24'h001000);
		word(18'h04000, 25'h0004000);
		word(18'h04000, 25'h0003800);
		gsee(1'b0, 24'h000E00);
		amin <= 16'h8000;
		thr <= 8'h7E;
		cdma <= 1'b1;
		do_reset();
		prep(1'b0, 24'h001000);
		word(18'h00400, 25'h0000400);
		word(18'h00400, 25'h0000420);
		gsee(1'b0, 24'h001104);
		gsee(1'b1, 24'h001000);
		word(18'h00400, 25'h0000400);
		word(18'h00400, 25'h0000420);
		gsee(1'b1, 24'h001104);
		cdma <= 1'b0;
		gmon <= 1'b1;
		do_reset();
		prep(1'b1, 24'h100000);
		word(18'h00040, 25'h0004040);
		word(18'h00040, 25'h0004000);
		word(18'h00000, 25'h0000040);
		word(18'h00000, 25'h0000008);
		word(18'h00000, 25'h0000040);
		word(18'h01000, 25'h001FC04);
		gmon <= 1'b0;
		zmask <= 4'hF;
		zlim <= 4'h0;
		e_zro <= 4'h0;
		do_reset();
		prep(1'b0, 24'h001000);
		word(18'h00C00, 25'h0000C00);
		word(18'h00C00, 25'h0000C60);
		gsee(1'b0, 24'h001290);
		zmask <= 4'h0;
		zlim <= 4'hF;
		slim <= 4'h0;
		e_sat <= 4'h1;
		prep(1'b0, 24'h001000);
		word(18'h1FFFF, 25'h001FFFF);
		word(18'h1FFFF, 25'h001BFFF);
		gsee(1'b0, 24'h000EE0);
		slim <= 4'hF;
		prep(1'b1, 24'h001000);
		c0 = cnt;
		stall <= 1'b1;
		tick(1);
		send(18'h00001, w);
		send(18'h00002, w);
		fork
			begin
				tick(6);
				stall <= 1'b0;
			end
		join_none
		send(18'h00003, w);
		check(w > 3, 1'b1);
		valid <= 1'b0;
		tick(5);
		check(cnt, c0 + 8'h03);
		check(last, 25'h0000003);
		end_of_test();
	end
endmodule
